// ### verilog/wdt_core.sv
// Watchdog timer core with fuse-selected safety level and timed change window
//
// Notes on behaviour
// - The counter advances on a 1 MHz oscillator tick, not the system clock.
// - The restart input clears the counter so a fresh period begins.
// - The counter is also cleared while disabled and on any chip reset.
// - When the selected period elapses unrestarted, a system reset pulse is issued.
// - Three-bit period code selects 16K doubling up to 2048K oscillator cycles.
// - Fuse unprogrammed: level 1, initially off; programmed: level 2, initially on.
// - Level 2 keeps the watchdog running and ignores every disable attempt.
// - Period changes are taken only while the change window is open.
// - Control bits 7 to 5 always read zero.
// - Change-enable bit clears itself four system cycles after being set.
// - Writing enable one starts; writing zero stops only inside the window.
// - The period field sets the time-out length, in oscillator cycles, counted while enabled.
// - Level 1 allows enabling by a plain write at any time.
// - Level 2 reads enable as one and ignores written enable values.
`timescale 1ns/100ps
`include "wdt_defines.svh"

module wdt_core #(
  parameter int unsigned P_BASE_CYCLES = `WDT_BASE_CYC
) (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  // Register port
  input  wire logic [`WDT_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wr_data,
  input  wire logic                   i_wr_stb,
  input  wire logic                   i_rd_stb,
  output logic      [7:0]             o_rd_data,
  // Restart request from the instruction decoder
  input  wire logic                   i_restart,
  // Safety level fuse, high when programmed
  input  wire logic                   i_safety_level_fuse,
  // System reset request and run indication
  output logic                        o_sys_reset,
  output logic                        o_wdt_running
);

  wdt_pkg::wdt_core_t core_reg;
  wdt_pkg::wdt_core_t core_next;

  logic                  osc_tick;
  logic                  fuse_sync;
  logic                  wr_ctrl;
  logic                  rd_ctrl;
  logic                  rd_stat;
  logic                  wd_ce;
  logic                  wd_en;
  logic [2:0]            wd_per;
  logic                  win_open;
  logic [`WDT_LIM_W-1:0] limit;
  logic                  at_limit;
  logic [7:0]            ctrl_view;
  logic [7:0]            stat_view;

  // Oscillator tick derived from the reference clock
  // Exact divided rate; a real oscillator drifts with supply and temperature
  wdt_tick_div #(
    .P_DIV (`WDT_OSC_DIV)
  ) u_tick_div (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .o_tick    (osc_tick)
  );

  // Fuse is a pin level, synchronised before use
  wdt_sync2 u_fuse_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_safety_level_fuse),
    .o_sync    (fuse_sync)
  );

  // Address decode and written fields
  assign wr_ctrl  = i_wr_stb && (i_addr == `WDT_CTRL_ADDR);
  assign rd_ctrl  = i_rd_stb && (i_addr == `WDT_CTRL_ADDR);
  assign rd_stat  = i_rd_stb && (i_addr == `WDT_STAT_ADDR);
  assign wd_ce    = i_wr_data[`WDT_CE_BIT];
  assign wd_en    = i_wr_data[`WDT_EN_BIT];
  assign wd_per   = i_wr_data[`WDT_PER_MSB:`WDT_PER_LSB];
  assign win_open = (core_reg.ce_cnt != `WDT_CE_CNT_RST);

  // Time-out length doubles per period code step
  assign limit    = `WDT_LIM_W'(P_BASE_CYCLES) << core_reg.period;
  // At or past limit minus one, so a period shortened below the count bites on the next tick
  assign at_limit = ({1'b0, core_reg.cnt} >= (limit - `WDT_LIM_W'(1)));

  // Readable views; reserved bits tied low
  always_comb begin
    ctrl_view                             = 8'h00;
    ctrl_view[`WDT_CE_BIT]                = win_open;
    ctrl_view[`WDT_EN_BIT]                = core_reg.en;
    ctrl_view[`WDT_PER_MSB:`WDT_PER_LSB]  = core_reg.period;
    stat_view                             = 8'h00;
    stat_view[`WDT_ST_LVL2_BIT]           = core_reg.level2;
    stat_view[`WDT_ST_WIN_BIT]            = win_open;
    stat_view[`WDT_ST_EN_BIT]             = core_reg.en;
  end

  // Next-state logic for the whole core
  always_comb begin
    core_next         = core_reg;
    core_next.sys_rst = 1'b0;
    core_next.rd_data = 8'h00;
    case (core_reg.state)
      wdt_pkg::WDT_BOOT: begin
        // Wait for the synchroniser, then latch the safety level
        if (core_reg.boot_cnt == `WDT_BOOT_CYC) begin
          core_next.level2 = fuse_sync;
          core_next.en     = fuse_sync;
          core_next.state  = wdt_pkg::WDT_RUN;
        end else begin
          core_next.boot_cnt = core_reg.boot_cnt + 2'h1;
        end
      end
      wdt_pkg::WDT_RUN: begin
        // Window closes by itself after four cycles
        if (win_open) begin
          core_next.ce_cnt = core_reg.ce_cnt - 3'h1;
        end
        if (wr_ctrl) begin
          if (wd_ce && wd_en) begin
            // Opening write; also enables, as enable is written one
            core_next.ce_cnt = `WDT_CE_WIN_CYC;
            core_next.en     = 1'b1;
          end else if (win_open && !wd_ce) begin
            // Completing write inside the window
            core_next.period = wd_per;
            core_next.ce_cnt = `WDT_CE_CNT_RST;
            if (!core_reg.level2) begin
              core_next.en = wd_en;
            end
          end else if (wd_en) begin
            // Plain enable, no sequence needed
            core_next.en = 1'b1;
          end
          // Any other write leaves period and enable alone
        end
        // Level 2 cannot be switched off by any write
        if (core_reg.level2) begin
          core_next.en = 1'b1;
        end
        // Counter: restart and disable clear, tick advances
        if (!core_next.en || i_restart) begin
          core_next.cnt = `WDT_CNT_RST;
        end else if (osc_tick) begin
          if (at_limit) begin
            core_next.cnt     = `WDT_CNT_RST;
            core_next.sys_rst = 1'b1;
          end else begin
            core_next.cnt = core_reg.cnt + `WDT_CNT_W'(1);
          end
        end
      end
      default: begin
        core_next       = '0;
        core_next.state = wdt_pkg::WDT_BOOT;
      end
    endcase
    // Read data valid in the cycle after the strobe only
    if (rd_ctrl) begin
      core_next.rd_data = ctrl_view;
    end else if (rd_stat) begin
      core_next.rd_data = stat_view;
    end
  end

  // State register; chip reset clears everything including the counter
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      core_reg        <= '0;
      core_reg.state  <= wdt_pkg::WDT_BOOT;
      core_reg.period <= `WDT_PER_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // Outputs straight from flip-flops
  // A bite does not reset this core; the chip reset is expected to follow
  assign o_rd_data     = core_reg.rd_data;
  assign o_sys_reset   = core_reg.sys_rst;
  assign o_wdt_running = core_reg.en;

  // Assertions on the reference clock, quiet while the chip reset is low
  default clocking wdt_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // Helper: the opening write as seen by the core
  logic open_wr;
  assign open_wr = wr_ctrl && wd_ce && wd_en && (core_reg.state == wdt_pkg::WDT_RUN);

  // Oscillator ticks are far apart
  tick_spacing_a: assert property (
    osc_tick |=> (!osc_tick) [*8])
    else $error("oscillator tick came too soon");

  restart_clears_a: assert property (
    (core_reg.state == wdt_pkg::WDT_RUN) && i_restart |=> core_reg.cnt == `WDT_CNT_RST)
    else $error("restart did not clear counter");

  disabled_clear_a: assert property (
    !core_reg.en |-> core_reg.cnt == `WDT_CNT_RST)
    else $error("counter running while disabled");

  timeout_reset_a: assert property (
    (core_reg.state == wdt_pkg::WDT_RUN) && core_reg.en && osc_tick && at_limit
      && !i_restart && !wr_ctrl |=> o_sys_reset && core_reg.cnt == `WDT_CNT_RST)
    else $error("time-out did not raise reset");

  reset_cause_a: assert property (
    o_sys_reset |-> $past(osc_tick) && {1'b0, $past(core_reg.cnt)} >= $past(limit) - `WDT_LIM_W'(1)
      && !$past(o_sys_reset))
    else $error("reset raised at wrong count");

  boot_level_a: assert property (
    $past(core_reg.state) == wdt_pkg::WDT_BOOT && core_reg.state == wdt_pkg::WDT_RUN
      |-> core_reg.en == core_reg.level2)
    else $error("initial enable does not match level");

  level2_on_a: assert property (
    core_reg.level2 && (core_reg.state == wdt_pkg::WDT_RUN) |-> core_reg.en && ctrl_view[`WDT_EN_BIT])
    else $error("level 2 watchdog was disabled");

  period_hold_a: assert property (
    wr_ctrl && !win_open |=> $stable(core_reg.period))
    else $error("period changed outside window");

  reserved_zero_a: assert property (
    rd_ctrl |=> o_rd_data[`WDT_RES_MSB:`WDT_RES_LSB] == 3'h0 && o_rd_data[2:0] == $past(core_reg.period))
    else $error("reserved bits read nonzero");

  window_opens_a: assert property (
    open_wr |=> win_open)
    else $error("window did not open");

  window_closes_a: assert property (
    open_wr ##1 (!i_wr_stb) [*4] |=> !win_open)
    else $error("window did not close after four cycles");

  enable_write_a: assert property (
    wr_ctrl && wd_en && (core_reg.state == wdt_pkg::WDT_RUN) |=> core_reg.en)
    else $error("enable write ignored");

  no_disable_closed_a: assert property (
    core_reg.en && !win_open && !(wr_ctrl && wd_ce) |=> core_reg.en)
    else $error("disabled without window");

  // Oscillator rate, counter stepping and bite
  tick_period_a: assert property (
    osc_tick |-> ##40 osc_tick)
    else $error("oscillator tick period wrong");

  count_hold_a: assert property (
    !osc_tick |=> core_reg.cnt == $past(core_reg.cnt) || core_reg.cnt == `WDT_CNT_RST)
    else $error("counter moved without a tick");

  count_step_a: assert property (
    core_reg.en && osc_tick && !at_limit && !i_restart && !wr_ctrl
      |=> core_reg.cnt == $past(core_reg.cnt) + `WDT_CNT_W'(1))
    else $error("counter did not step on a tick");

  boot_quiet_a: assert property (
    core_reg.state == wdt_pkg::WDT_BOOT |-> !o_sys_reset && !core_reg.en && core_reg.cnt == `WDT_CNT_RST)
    else $error("watchdog active during boot");

  restart_no_bite_a: assert property (
    i_restart && (core_reg.state == wdt_pkg::WDT_RUN) |=> !o_sys_reset)
    else $error("reset issued despite restart");

  reset_pulse_a: assert property (
    o_sys_reset |=> !o_sys_reset)
    else $error("system reset longer than one cycle");

  disabled_no_bite_a: assert property (
    !core_reg.en && !wr_ctrl |=> !o_sys_reset)
    else $error("reset issued while disabled");

  level_fixed_a: assert property (
    core_reg.state == wdt_pkg::WDT_RUN |=> $stable(core_reg.level2))
    else $error("safety level changed after boot");

  // Change window
  period_take_a: assert property (
    wr_ctrl && win_open && !wd_ce |=> core_reg.period == $past(wd_per))
    else $error("period not taken inside window");

  window_shut_a: assert property (
    wr_ctrl && win_open && !wd_ce |=> !win_open)
    else $error("completing write left window open");

  window_holds_a: assert property (
    open_wr ##1 (!i_wr_stb) [*3] |=> win_open)
    else $error("window closed before four cycles");

  win_only_run_a: assert property (
    win_open |-> core_reg.state == wdt_pkg::WDT_RUN)
    else $error("window open during boot");

  window_arm_a: assert property (
    open_wr |=> core_reg.ce_cnt == `WDT_CE_WIN_CYC && core_reg.en)
    else $error("opening write did not arm a full window");

  window_disable_a: assert property (
    wr_ctrl && win_open && !wd_ce && !wd_en && !core_reg.level2
      |=> !core_reg.en && core_reg.cnt == `WDT_CNT_RST)
    else $error("disable inside window refused");

  closed_stays_a: assert property (
    wr_ctrl && !win_open && !(wd_ce && wd_en) |=> !win_open)
    else $error("window opened by a plain write");

  // Read-back
  rd_idle_a: assert property (
    !i_rd_stb |=> o_rd_data == 8'h00)
    else $error("read data outside read cycle");

  status_zero_a: assert property (
    rd_stat |=> o_rd_data[7:3] == 5'h00)
    else $error("unused status bits read nonzero");

  read_flags_a: assert property (
    rd_ctrl |=> o_rd_data[`WDT_CE_BIT] == $past(win_open) && o_rd_data[`WDT_EN_BIT] == $past(core_reg.en))
    else $error("control flags read back wrong");

  level2_read_a: assert property (
    core_reg.level2 && rd_ctrl |=> o_rd_data[`WDT_EN_BIT])
    else $error("level 2 enable read as zero");

  // Main scenarios
  cov_timeout: cover property (o_sys_reset);
  cov_disable: cover property (open_wr ##[1:4] (wr_ctrl && !wd_en && !wd_ce) ##1 !core_reg.en);
  cov_period:  cover property (open_wr ##[1:4] (wr_ctrl && !wd_ce) ##1 $changed(core_reg.period));
  cov_restart: cover property (core_reg.en && i_restart && core_reg.cnt != `WDT_CNT_RST);
  cov_level2:  cover property ((core_reg.level2 && open_wr) ##[1:4] (wr_ctrl && !wd_ce));

endmodule : wdt_core

// ### verilog/wdt_defines.svh
// Register map, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// Register addresses on the plain register port
`define WDT_ADDR_W       8
`define WDT_CTRL_ADDR    8'h00
`define WDT_STAT_ADDR    8'h01

// Control register field positions
`define WDT_RES_MSB      7
`define WDT_RES_LSB      5
`define WDT_CE_BIT       4
`define WDT_EN_BIT       3
`define WDT_PER_MSB      2
`define WDT_PER_LSB      0

// Status register field positions
`define WDT_ST_LVL2_BIT  0
`define WDT_ST_WIN_BIT   1
`define WDT_ST_EN_BIT    2

// Reset values
`define WDT_PER_RST      3'h0
`define WDT_CE_CNT_RST   3'h0
`define WDT_CNT_RST      21'h000000

// Timing: reference clock, watchdog oscillator and derived divider
`define WDT_REF_HZ       40000000
`define WDT_OSC_HZ       1000000
`define WDT_OSC_DIV      (`WDT_REF_HZ / `WDT_OSC_HZ)
`define WDT_DIV_W        6

// Shortest time-out in oscillator cycles, code 000
`define WDT_BASE_CYC     16384
`define WDT_CNT_W        21
`define WDT_LIM_W        22

// Change window length in reference clock cycles
`define WDT_CE_WIN_CYC   3'h4

// Cycles spent settling the fuse synchroniser after reset
`define WDT_BOOT_CYC     2'h3

`endif

// ### verilog/wdt_pkg.sv
// Types shared by the watchdog design files
`include "wdt_defines.svh"

package wdt_pkg;

  // Core sequencing: settle the fuse, then run
  typedef enum logic [0:0] {
    WDT_BOOT,
    WDT_RUN
  } wdt_state_t;

  // Complete state of the watchdog core
  typedef struct packed {
    wdt_state_t              state;
    logic [1:0]              boot_cnt;
    logic                    level2;
    logic                    en;
    logic [2:0]              ce_cnt;
    logic [2:0]              period;
    logic [`WDT_CNT_W-1:0]   cnt;
    logic                    sys_rst;
    logic [7:0]              rd_data;
  } wdt_core_t;

endpackage : wdt_pkg

// ### verilog/wdt_sync2.sv
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/100ps

module wdt_sync2 (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Asynchronous level in, synchronised level out
  input  wire logic i_async,
  output logic      o_sync
);

  typedef struct packed {
    logic meta;
    logic sync;
  } wdt_sync_t;

  wdt_sync_t sync_reg;
  wdt_sync_t sync_next;

  // First stage feeds only the second stage
  always_comb begin
    sync_next      = sync_reg;
    sync_next.meta = i_async;
    sync_next.sync = sync_reg.meta;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg.sync;

endmodule : wdt_sync2

// ### verilog/wdt_tick_div.sv
// Divider that turns the reference clock into a one-cycle oscillator tick
`timescale 1ns/100ps
`include "wdt_defines.svh"

module wdt_tick_div #(
  parameter int unsigned P_DIV = `WDT_OSC_DIV
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // One pulse every P_DIV cycles
  output logic      o_tick
);

  typedef struct packed {
    logic [`WDT_DIV_W-1:0] cnt;
    logic                  tick;
  } wdt_div_t;

  wdt_div_t div_reg;
  wdt_div_t div_next;

  // Wrap at P_DIV - 1 and flag the wrap
  always_comb begin
    div_next      = div_reg;
    div_next.tick = 1'b0;
    if (div_reg.cnt == `WDT_DIV_W'(P_DIV - 1)) begin
      div_next.cnt  = '0;
      div_next.tick = 1'b1;
    end else begin
      div_next.cnt = div_reg.cnt + `WDT_DIV_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign o_tick = div_reg.tick;

endmodule : wdt_tick_div

// ### bench/tb_top.sv
// Self-checking testbench for the watchdog core, driven straight at its ports
`timescale 1ns/100ps
`include "wdt_defines.svh"

module tb_top;
  // Short base count keeps the longest period inside the run budget
  localparam int unsigned BASE = 4;
  localparam int unsigned TICK = `WDT_OSC_DIV;
  localparam logic [7:0]  CTRL = `WDT_CTRL_ADDR;

  logic       i_ref_clk           = 1'b0;
  logic       i_rstn              = 1'b0;
  logic [7:0] i_addr              = 8'h00;
  logic [7:0] i_wr_data           = 8'h00;
  logic       i_wr_stb            = 1'b0;
  logic       i_rd_stb            = 1'b0;
  logic       i_restart           = 1'b0;
  logic       i_safety_level_fuse = 1'b0;
  logic [7:0] o_rd_data;
  logic       o_sys_reset;
  logic       o_wdt_running;
  logic [7:0] rdv;
  int         error_cnt           = 0;
  int         check_count         = 0;

  wdt_core #(.P_BASE_CYCLES(BASE)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_restart(i_restart),
    .i_safety_level_fuse(i_safety_level_fuse), .o_sys_reset(o_sys_reset),
    .o_wdt_running(o_wdt_running)
  );

  // 40 MHz reference clock
  always #12.5 i_ref_clk = ~i_ref_clk;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // One-cycle write strobe; returns at the edge that takes it
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_ref_clk);
    i_wr_stb  <= 1'b1;
    i_addr    <= addr;
    i_wr_data <= data;
    @(posedge i_ref_clk);
    i_wr_stb  <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b1;
    i_addr   <= addr;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
    #1;
    data = o_rd_data;
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask : settle

  // Chip reset held four cycles, then boot allowed to finish
  task automatic rst(input logic fuse);
    @(posedge i_ref_clk);
    i_rstn              <= 1'b0;
    i_safety_level_fuse <= fuse;
    repeat (4) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask : rst

  task automatic kick();
    @(posedge i_ref_clk);
    i_restart <= 1'b1;
    @(posedge i_ref_clk);
    i_restart <= 1'b0;
  endtask : kick

  // Tick phase is unknown, so the bite may land up to one tick early
  task automatic expect_bite(input int unsigned ticks);
    int n = 0;
    while (o_sys_reset !== 1'b1 && n < ticks * TICK + 80) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk1(n >= (ticks - 1) * TICK && n <= ticks * TICK + 4, 1'b1);
  endtask : expect_bite

  // Watch for any bite, optionally restarting every 100 cycles
  task automatic hold_off(input int cycles, input bit kicking);
    int bites = 0;
    for (int i = 1; i <= cycles; i++) begin
      @(posedge i_ref_clk);
      i_restart <= kicking && (i % 100 == 0);
      #1;
      if (o_sys_reset === 1'b1) bites++;
    end
    @(posedge i_ref_clk);
    i_restart <= 1'b0;
    chk1(bites == 0, 1'b1);
  endtask : hold_off

  task automatic set_period(input logic [2:0] p);
    wr(CTRL, 8'h18);
    wr(CTRL, {5'h01, p});
  endtask : set_period

  task automatic t_boot_l1();
    rst(1'b0);
    chk1(o_wdt_running, 1'b0);
    rd(CTRL, rdv);
    chk8(rdv, 8'h00);
    rd(8'h7F, rdv);
    chk8(rdv, 8'h00);
    wr(CTRL, 8'hEB);
    settle();
    chk1(o_wdt_running, 1'b1);
    rd(CTRL, rdv);
    chk8(rdv, 8'h08);
    $display("boot and plain enable done");
  endtask : t_boot_l1

  task automatic t_window();
    wr(CTRL, 8'h18);
    rd(CTRL, rdv);
    chk8(rdv, 8'h18);
    rd(`WDT_STAT_ADDR, rdv);
    chk8(rdv, 8'h06);
    repeat (4) @(posedge i_ref_clk);
    rd(CTRL, rdv);
    chk8(rdv, 8'h08);
    // Disable one cycle too late must be refused
    wr(CTRL, 8'h18);
    repeat (3) @(posedge i_ref_clk);
    wr(CTRL, 8'h00);
    settle();
    chk1(o_wdt_running, 1'b1);
    // Last legal cycle of the window
    wr(CTRL, 8'h18);
    repeat (2) @(posedge i_ref_clk);
    wr(CTRL, 8'h00);
    settle();
    chk1(o_wdt_running, 1'b0);
    $display("change window done");
  endtask : t_window

  // Partly filled counter must restart from zero after a disable
  task automatic t_clear_on_disable();
    wr(CTRL, 8'h08);
    kick();
    hold_off(100, 1'b0);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h00);
    hold_off(400, 1'b0);
    wr(CTRL, 8'h08);
    expect_bite(BASE);
    $display("clear on disable done");
  endtask : t_clear_on_disable

  task automatic t_restart();
    hold_off(800, 1'b1);
    kick();
    expect_bite(BASE);
    $display("restart done");
  endtask : t_restart

  task automatic t_periods();
    for (int p = 0; p < 8; p++) begin
      set_period(p[2:0]);
      rd(CTRL, rdv);
      chk8(rdv, 8'h08 | 8'(p));
      kick();
      expect_bite(BASE << p);
    end
    set_period(3'h0);
    $display("period codes done");
  endtask : t_periods

  task automatic t_level2();
    rst(1'b1);
    chk1(o_wdt_running, 1'b1);
    rd(`WDT_STAT_ADDR, rdv);
    chk8(rdv, 8'h05);
    wr(CTRL, 8'h00);
    rd(CTRL, rdv);
    chk8(rdv, 8'h08);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h00);
    settle();
    chk1(o_wdt_running, 1'b1);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h02);
    rd(CTRL, rdv);
    chk8(rdv, 8'h0A);
    kick();
    expect_bite(BASE << 2);
    $display("safety level 2 done");
  endtask : t_level2

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    t_boot_l1();
    t_window();
    t_clear_on_disable();
    t_restart();
    t_periods();
    t_level2();
    report_and_stop();
  end

  // Hang guard: the sequence needs about 43000 cycles
  initial begin
    #(25 * 70000);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top
